// ### rtl/nci_consts.svh
`ifndef NCI_CONSTS_SVH
`define NCI_CONSTS_SVH

`define NCI_CLK_NS       10
`define NCI_CYC_UP(ns)   (((ns) + `NCI_CLK_NS - 1) / `NCI_CLK_NS)

// Strobe timing in ns, and cycle counts derived from them
`define NCI_T_WP_NS      25
`define NCI_T_WH_NS      15
`define NCI_T_RLQV_NS    30
`define NCI_T_REH_NS     15
`define NCI_T_WB_NS      100
`define NCI_WP_CYC       `NCI_CYC_UP(`NCI_T_WP_NS)
`define NCI_WH_CYC       `NCI_CYC_UP(`NCI_T_WH_NS)
`define NCI_REH_CYC      `NCI_CYC_UP(`NCI_T_REH_NS)
`define NCI_WB_CYC       `NCI_CYC_UP(`NCI_T_WB_NS)
// Read strobe low time covers access time plus the input synchroniser
`define NCI_SYNC_CYC     2
`define NCI_RLO_CYC      (`NCI_CYC_UP(`NCI_T_RLQV_NS) + `NCI_SYNC_CYC + 1)

// Command codes
`define NCI_C_READ       8'h00
`define NCI_C_READ_GO    8'h30
`define NCI_C_CACHE_GO   8'h31
`define NCI_C_CACHE_EXIT 8'h34
`define NCI_C_ROUT       8'h05
`define NCI_C_ROUT_GO    8'he0
`define NCI_C_PROG       8'h80
`define NCI_C_PROG_GO    8'h10

// Address layout
`define NCI_PAGE_BYTES   2112
`define NCI_ADDR_FULL    3'h4
`define NCI_ADDR_COL     3'h1

`endif

// ### rtl/nci_host.sv
`timescale 1ns/1ns
`include "nci_consts.svh"
module nci_host import nci_pkg::*; #(
  parameter int PAGE_BYTES = `NCI_PAGE_BYTES
) (
  input  wire logic        ref_clk,          // System clock, 100 MHz
  input  wire logic        reset_n,          // Async reset, active low
  // User side
  input  wire logic        cmd_valid,        // Operation request
  output logic             cmd_ready,        // Idle, request taken
  input  wire nci_op_e     cmd_op,           // Operation code
  input  wire logic [10:0] cmd_block,        // Block number
  input  wire logic [6:0]  cmd_page,         // Page within block
  input  wire logic [11:0] cmd_col,          // Column
  input  wire logic [12:0] cmd_len,          // Byte count
  input  wire logic [7:0]  wr_data,          // Program data byte
  input  wire logic        wr_valid,         // Program data valid
  output logic             wr_ready,         // Program byte taken
  output logic [7:0]  rd_data,               // Read data byte
  output logic        rd_valid,              // Read data strobe
  output logic        op_done,               // Operation finished
  output logic        op_err,                // Request refused
  output logic        cache_on,              // Cache read running
  // Flash pins
  output logic        chip_sel_n,            // Chip select, low active
  output logic        cmd_latch_strobe,      // Command latch
  output logic        addr_latch_strobe,     // Address latch
  output logic        write_strobe_n,        // Write strobe
  output logic        read_strobe_n,         // Read strobe
  output logic        write_protect_n,       // Write protect, low guards
  output logic [7:0]  io_out,                // Data lines out
  output logic        io_oe,                 // Data lines drive enable
  input  wire logic [7:0] io_in,             // Data lines in
  input  wire logic   busy_flag_n            // Ready/busy, low busy
);

  localparam logic [7:0] WP_CYC  = 8'(`NCI_WP_CYC);
  localparam logic [7:0] WCY_END = 8'(`NCI_WP_CYC + `NCI_WH_CYC);
  localparam logic [7:0] RLO_CYC = 8'(`NCI_RLO_CYC);
  localparam logic [7:0] RCY_END = 8'(`NCI_RLO_CYC + `NCI_REH_CYC - 1);
  localparam logic [7:0] WB_CYC  = 8'(`NCI_WB_CYC);
  localparam logic [12:0] PAGE_N = 13'(PAGE_BYTES);

  nci_regs_s s;
  nci_regs_s next_s;
  logic [7:0] io_sync;
  logic       ready_sync;
  logic [13:0] prog_end;
  logic        refuse;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  nci_sync #(.WIDTH(9)) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({busy_flag_n, io_in}),
    .sync_out ({ready_sync, io_sync})
  );

  // ****************************************************************
  // Address byte layout
  // ****************************************************************
  function automatic logic [7:0] addr_byte(input logic [2:0]  i,
                                           input logic [17:0] row,
                                           input logic [11:0] col);
    case (i)
      3'h0:    addr_byte = col[7:0];
      3'h1:    addr_byte = {4'h0, col[11:8]};
      3'h2:    addr_byte = row[7:0];
      3'h3:    addr_byte = row[15:8];
      3'h4:    addr_byte = {6'h00, row[17:16]};
      default: addr_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] first_code(input nci_op_e op);
    case (op)
      NCI_OP_READ_CONT:  first_code = `NCI_C_READ_GO;
      NCI_OP_CACHE_EXIT: first_code = `NCI_C_CACHE_EXIT;
      NCI_OP_RAND_OUT:   first_code = `NCI_C_ROUT;
      NCI_OP_PROGRAM:    first_code = `NCI_C_PROG;
      default:           first_code = `NCI_C_READ;
    endcase
  endfunction

  function automatic logic [7:0] confirm_code(input nci_op_e op);
    case (op)
      NCI_OP_CACHE:    confirm_code = `NCI_C_CACHE_GO;
      NCI_OP_RAND_OUT: confirm_code = `NCI_C_ROUT_GO;
      NCI_OP_PROGRAM:  confirm_code = `NCI_C_PROG_GO;
      default:         confirm_code = `NCI_C_READ_GO;
    endcase
  endfunction

  // ****************************************************************
  // Request checks
  // ****************************************************************
  assign prog_end = {2'b00, cmd_col} + {1'b0, cmd_len};

  always_comb begin
    refuse = 1'b0;
    case (cmd_op)
      NCI_OP_RAND_OUT:   refuse = s.cache;
      NCI_OP_CACHE_EXIT: refuse = !s.cache;
      NCI_OP_STREAM:     refuse = 1'b0;
      // Zero bytes or a run past the page end cannot be programmed,
      // and the last page programmed is not hit a second time
      NCI_OP_PROGRAM:    refuse = s.cache || cmd_len == 13'h0000
                                  || prog_end > {1'b0, PAGE_N}
                                  || (s.last_ok
                                      && s.last_row == {cmd_block, cmd_page});
      default:           refuse = s.cache;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_s          = s;
    next_s.rd_valid = 1'b0;
    next_s.done     = 1'b0;
    next_s.err      = 1'b0;
    next_s.cnt      = s.cnt + 8'h01;
    case (s.st)
      NCI_ST_IDLE: begin
        next_s.cnt = 8'h00;
        if (cmd_valid) begin
          if (refuse) begin
            next_s.err = 1'b1;
          end else begin
            next_s.op  = cmd_op;
            next_s.idx = 3'h0;
            next_s.row = {cmd_block, cmd_page};
            next_s.len = cmd_len;
            if (cmd_op == NCI_OP_CACHE) begin
              next_s.col = 12'h000;
            end else if (cmd_op != NCI_OP_STREAM && cmd_op != NCI_OP_READ_CONT) begin
              next_s.col = cmd_col;
            end
            next_s.ce_n = 1'b0;
            if (cmd_op == NCI_OP_STREAM) begin
              next_s.st = NCI_ST_DOUT;
            end else begin
              next_s.st     = NCI_ST_CMD1;
              next_s.cle    = 1'b1;
              next_s.io_oe  = 1'b1;
              next_s.io_out = first_code(cmd_op);
              next_s.wp_n   = (cmd_op == NCI_OP_PROGRAM);
            end
          end
        end
      end
      NCI_ST_CMD1: begin
        if (s.cnt == WCY_END) begin
          next_s.cnt = 8'h00;
          next_s.cle = 1'b0;
          case (s.op)
            NCI_OP_READ_CONT, NCI_OP_CACHE_EXIT: begin
              next_s.st    = NCI_ST_WAIT;
              next_s.io_oe = 1'b0;
            end
            default: begin
              next_s.st     = NCI_ST_ADDR;
              next_s.ale    = 1'b1;
              next_s.io_out = addr_byte(3'h0, s.row, next_s.col);
            end
          endcase
        end
      end
      NCI_ST_ADDR: begin
        if (s.cnt == WCY_END) begin
          next_s.cnt = 8'h00;
          // Stop after the last needed byte, never a sixth
          if (s.idx == ((s.op == NCI_OP_RAND_OUT) ? `NCI_ADDR_COL
                                                  : `NCI_ADDR_FULL)) begin
            next_s.ale = 1'b0;
            if (s.op == NCI_OP_PROGRAM) begin
              next_s.st = NCI_ST_DIN;
            end else begin
              next_s.st     = NCI_ST_CMD2;
              next_s.cle    = 1'b1;
              next_s.io_out = confirm_code(s.op);
            end
          end else begin
            next_s.idx    = s.idx + 3'h1;
            next_s.io_out = addr_byte(s.idx + 3'h1, s.row, s.col);
          end
        end
      end
      NCI_ST_DIN: begin
        if (s.cnt == 8'h00) begin
          // Hold in setup until the source has a byte
          if (wr_valid) begin
            next_s.io_out = wr_data;
          end else begin
            next_s.cnt = 8'h00;
          end
        end else if (s.cnt == WCY_END) begin
          next_s.cnt = 8'h00;
          next_s.len = s.len - 13'h0001;
          if (s.len == 13'h0001) begin
            next_s.st     = NCI_ST_CMD2;
            next_s.cle    = 1'b1;
            next_s.io_out = confirm_code(s.op);
          end
        end
      end
      NCI_ST_CMD2: begin
        if (s.cnt == WCY_END) begin
          next_s.cnt   = 8'h00;
          next_s.cle   = 1'b0;
          next_s.io_oe = 1'b0;
          next_s.st    = (s.op == NCI_OP_RAND_OUT) ? NCI_ST_DOUT : NCI_ST_WAIT;
        end
      end
      NCI_ST_WAIT: begin
        // Busy is only trusted after the device has had time to pull it
        if (s.cnt >= WB_CYC) begin
          next_s.cnt = WB_CYC;
          if (ready_sync) begin
            next_s.cnt = 8'h00;
            case (s.op)
              NCI_OP_PROGRAM: begin
                next_s.st       = NCI_ST_DONE;
                next_s.last_row = s.row;
                next_s.last_ok  = 1'b1;
              end
              NCI_OP_CACHE_EXIT: begin
                next_s.st    = NCI_ST_DONE;
                next_s.cache = 1'b0;
              end
              NCI_OP_CACHE: begin
                next_s.st    = NCI_ST_DOUT;
                next_s.cache = 1'b1;
              end
              default: next_s.st = NCI_ST_DOUT;
            endcase
          end
        end
      end
      NCI_ST_DOUT: begin
        if (s.len == 13'h0000 || (!s.cache && s.cnt == 8'h00
                                  && {1'b0, s.col} >= PAGE_N)) begin
          next_s.st  = NCI_ST_DONE;
          next_s.cnt = 8'h00;
        end else if (s.cnt == RLO_CYC - 8'h01) begin
          next_s.rd_data  = io_sync;
          next_s.rd_valid = 1'b1;
        end else if (s.cnt == RCY_END) begin
          next_s.cnt = 8'h00;
          next_s.len = s.len - 13'h0001;
          // Cache pages chain, so the column wraps onto the next page
          if (s.cache && {1'b0, s.col} == PAGE_N - 13'h0001) begin
            next_s.col = 12'h000;
          end else begin
            next_s.col = s.col + 12'h001;
          end
        end
      end
      NCI_ST_DONE: begin
        next_s.st   = NCI_ST_IDLE;
        next_s.cnt  = 8'h00;
        next_s.done = 1'b1;
        next_s.ce_n = 1'b1;
        next_s.wp_n = 1'b0;
        next_s.io_oe = 1'b0;
      end
      default: begin
        next_s.st  = NCI_ST_IDLE;
        next_s.cnt = 8'h00;
      end
    endcase
    // Strobes follow the cycle counter; count zero is write setup time, the read strobe is already low there
    next_s.we_n = !((next_s.st == NCI_ST_CMD1 || next_s.st == NCI_ST_ADDR
                     || next_s.st == NCI_ST_DIN || next_s.st == NCI_ST_CMD2)
                    && next_s.cnt != 8'h00 && next_s.cnt <= WP_CYC);
    // No strobe past the page end outside cache read, the device would move on
    next_s.re_n = !(next_s.st == NCI_ST_DOUT && next_s.cnt < RLO_CYC
                    && next_s.len != 13'h0000
                    && (next_s.cache || {1'b0, next_s.col} < PAGE_N));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.st       <= NCI_ST_IDLE;
      s.op       <= NCI_OP_READ;
      s.ce_n     <= 1'b1;
      s.we_n     <= 1'b1;
      s.re_n     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready         = (s.st == NCI_ST_IDLE);
  assign wr_ready          = (s.st == NCI_ST_DIN) && s.cnt == 8'h00;
  assign rd_data           = s.rd_data;
  assign rd_valid          = s.rd_valid;
  assign op_done           = s.done;
  assign op_err            = s.err;
  assign cache_on          = s.cache;
  assign chip_sel_n        = s.ce_n;
  assign cmd_latch_strobe  = s.cle;
  assign addr_latch_strobe = s.ale;
  assign write_strobe_n    = s.we_n;
  assign read_strobe_n     = s.re_n;
  assign write_protect_n   = s.wp_n;
  assign io_out            = s.io_out;
  assign io_oe             = s.io_oe;

endmodule // nci_host

// ### rtl/nci_pkg.sv
package nci_pkg;

  typedef enum logic [2:0] {
    NCI_OP_READ       = 3'h0,
    NCI_OP_READ_CONT  = 3'h1,
    NCI_OP_CACHE      = 3'h2,
    NCI_OP_CACHE_EXIT = 3'h3,
    NCI_OP_RAND_OUT   = 3'h4,
    NCI_OP_PROGRAM    = 3'h5,
    NCI_OP_STREAM     = 3'h6
  } nci_op_e;

  typedef enum logic [7:0] {
    NCI_ST_IDLE = 8'h01,
    NCI_ST_CMD1 = 8'h02,
    NCI_ST_ADDR = 8'h04,
    NCI_ST_DIN  = 8'h08,
    NCI_ST_CMD2 = 8'h10,
    NCI_ST_WAIT = 8'h20,
    NCI_ST_DOUT = 8'h40,
    NCI_ST_DONE = 8'h80
  } nci_state_e;

  typedef struct packed {
    nci_state_e  st;
    nci_op_e     op;
    logic [7:0]  cnt;
    logic [2:0]  idx;
    logic [12:0] len;
    logic [11:0] col;
    logic [17:0] row;
    logic [17:0] last_row;
    logic        last_ok;
    logic        cache;
    logic        ce_n;
    logic        cle;
    logic        ale;
    logic        we_n;
    logic        re_n;
    logic        wp_n;
    logic [7:0]  io_out;
    logic        io_oe;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        done;
    logic        err;
  } nci_regs_s;

endpackage

// ### rtl/nci_sync.sv
`timescale 1ns/1ns
module nci_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,  // System clock
  input  wire logic             reset_n,  // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Pin level from outside
  output logic      [WIDTH-1:0] sync_out  // Level after two flops
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // nci_sync

// ### testbench/nci_flash_model.sv
`timescale 1ns/1ns
module nci_flash_model (
  input  wire logic       chip_sel_n,        // Select
  input  wire logic       cmd_latch_strobe,  // Command latch
  input  wire logic       addr_latch_strobe, // Address latch
  input  wire logic       write_strobe_n,    // Write strobe
  input  wire logic       read_strobe_n,     // Read strobe
  input  wire logic       write_protect_n,   // Write protect
  input  wire logic       slow,              // Long busy times
  input  wire logic [7:0] io_bus,            // Bus level
  output logic      [7:0] io_drv,            // Read data
  output logic            busy_flag_n        // Ready/busy, pull-up
);
  logic [7:0]  mem [int];
  logic [7:0]  dbuf [$];
  logic [7:0]  ab [5];
  logic [7:0]  setup;
  logic [17:0] row;
  logic [11:0] col;
  logic        cache;
  logic        array_fetch_idle_bit;
  logic        cache_idle_bit;
  bit          used [int];
  int          na;
  int          faults;
  event        go;

  initial begin
    busy_flag_n = 1'b1;
    io_drv = 8'h00;
    cache = 1'b0;
    setup = 8'h00;
    na = 0;
    faults = 0;
  end

  task automatic take_addr();
    if (na == 5) begin
      col = {ab[1][3:0], ab[0]};
      row = {ab[4][1:0], ab[3], ab[2]};
      if (ab[1][7:4] != 4'h0 || ab[4][7:2] != 6'h0) faults++;
    end
    na = 0;
  endtask

  // ****************
  // Bus write cycles
  // ****************
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && read_strobe_n && cmd_latch_strobe && !addr_latch_strobe) begin
      case (io_bus)
        8'h00, 8'h05, 8'h80: begin
          setup = io_bus;
          na = 0;
          dbuf.delete();
        end
        8'h30, 8'h31: begin
          take_addr();
          cache = (io_bus == 8'h31);
          if (cache && col != 12'h000) faults++;
          array_fetch_idle_bit = !cache;
          -> go;
        end
        8'he0: if (!cache && setup == 8'h05 && na == 2) col = {ab[1][3:0], ab[0]};
        8'h10: begin
          take_addr();
          if (setup == 8'h80 && write_protect_n && dbuf.size() > 0) begin
            if (used.exists(row)) faults++;
            if (int'(col) + dbuf.size() > 2112) faults++;
            used[row] = 1'b1;
            foreach (dbuf[i]) mem[{row, col + 12'(i)}] = dbuf[i];
            -> go;
          end
        end
        8'h34: if (cache) begin
          cache = 1'b0;
          -> go;
        end
        default: ;
      endcase
    end else if (!chip_sel_n && read_strobe_n && addr_latch_strobe && !cmd_latch_strobe) begin
      if (na < 5) begin
        ab[na] = io_bus;
        na++;
      end
    end else if (!chip_sel_n && read_strobe_n && !addr_latch_strobe && setup == 8'h80)
      dbuf.push_back(io_bus);
  end

  // Cache read frees the pin after the first latency, the fetch idles later
  always @(go) begin
    busy_flag_n = 1'b0;
    cache_idle_bit = 1'b0;
    #(slow ? 2000 : 300);
    busy_flag_n = 1'b1;
    cache_idle_bit = 1'b1;
    array_fetch_idle_bit <= #(slow ? 2000 : 300) 1'b1;
  end

  always @(negedge read_strobe_n) begin
    if (!chip_sel_n) begin
      io_drv = ~io_drv;
      #20;
      io_drv = mem.exists({row, col}) ? mem[{row, col}] : row[7:0] ^ col[7:0] ^ {4'h5, col[11:8]};
      col = col + 12'h1;
      if (cache && col == 12'd2112) begin
        col = 12'h000;
        row = row + 18'h1;
      end
    end
  end
  // Released bus shows a moving value, not the last byte
  always @(posedge read_strobe_n or posedge chip_sel_n) io_drv = ~io_drv;
endmodule // nci_flash_model

// ### testbench/nci_host_bench.sv
`timescale 1ns/1ns
module nci_host_bench import nci_pkg::*;;
  logic        ref_clk, reset_n, cmd_valid, wr_valid, slow;
  nci_op_e     cmd_op;
  logic [10:0] cmd_block;
  logic [6:0]  cmd_page;
  logic [11:0] cmd_col, c0;
  logic [12:0] cmd_len;
  logic [7:0]  wr_data, rd_data, io_out, io_drv, io_bus;
  logic        cmd_ready, wr_ready, rd_valid, op_done, op_err, cache_on, io_oe, busy_flag_n;
  logic        chip_sel_n, cmd_latch_strobe, addr_latch_strobe;
  logic        write_strobe_n, read_strobe_n, write_protect_n;
  logic [9:0]  expq [$];
  logic [7:0]  pd [$];
  logic [7:0]  sh [int];
  logic [31:0] rs;
  logic [17:0] r1, r2;
  int          errors, cmp_count;

  assign io_bus = io_oe ? io_out : io_drv;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  nci_host nci_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_block(cmd_block), .cmd_page(cmd_page),
    .cmd_col(cmd_col), .cmd_len(cmd_len), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done),
    .op_err(op_err), .cache_on(cache_on), .chip_sel_n(chip_sel_n),
    .cmd_latch_strobe(cmd_latch_strobe), .addr_latch_strobe(addr_latch_strobe),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_bus),
    .busy_flag_n(busy_flag_n));
  nci_flash_model nci_flash_model_i (.chip_sel_n(chip_sel_n),
    .cmd_latch_strobe(cmd_latch_strobe), .addr_latch_strobe(addr_latch_strobe),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .write_protect_n(write_protect_n), .slow(slow), .io_bus(io_bus), .io_drv(io_drv),
    .busy_flag_n(busy_flag_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ex(input logic [17:0] r, input logic [11:0] c);
    return sh.exists({r, c}) ? sh[{r, c}] : r[7:0] ^ c[7:0] ^ {4'h5, c[11:8]};
  endfunction

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Notes: 00 byte, 01 done, 10 refused
  task automatic exp_rd(input logic [17:0] r, input logic [11:0] c, input int n);
    repeat (n) begin
      if (c == 12'd2112) begin
        c = 12'h000;
        r = r + 18'h1;
      end
      expq.push_back({2'b00, ex(r, c)});
      c = c + 12'h1;
    end
    expq.push_back(10'h100);
  endtask
  task automatic fill(input logic [17:0] r, input logic [11:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      rs = lfsr(rs);
      pd.push_back(rs[7:0]);
      sh[{r, c + 12'(i)}] = rs[7:0];
    end
    expq.push_back(10'h100);
  endtask

  task automatic req(input nci_op_e op, input logic [17:0] r, input logic [11:0] c,
                     input logic [12:0] n);
    int k;
    cmd_op <= op;
    {cmd_block, cmd_page} <= r;
    cmd_col <= c;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    wr_valid <= pd.size() > 0;
    if (pd.size() > 0) wr_data <= pd[0];
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 50);
    cmd_valid <= 1'b0;
    while (op_done !== 1'b1 && op_err !== 1'b1 && k < 40000) begin
      @(posedge ref_clk);
      k++;
      if (wr_ready === 1'b1 && pd.size() > 0) begin
        void'(pd.pop_front());
        wr_valid <= pd.size() > 0;
        if (pd.size() > 0) wr_data <= pd[0];
      end
    end
    if (k >= 40000) begin
      chk(1'b0, "no completion");
      test_done();
    end
  endtask
  task automatic refuse(input nci_op_e op, input logic [11:0] c, input logic [12:0] n);
    expq.push_back(10'h200);
    req(op, r2, c, n);
  endtask

  // ***************
  // Result watcher
  // ***************
  always @(posedge ref_clk) begin
    if (reset_n === 1'b1 && (rd_valid || op_done || op_err) === 1'b1) begin
      chk(expq.size() > 0, "unexpected result");
      if (expq.size() > 0)
        chk({op_err, op_done, rd_valid ? rd_data : 8'h00} === expq.pop_front(), "result");
    end
  end

  // ***************
  // Main sequence
  // ***************
  initial begin
    {reset_n, cmd_valid, wr_valid, slow, errors, cmp_count} = '0;
    {cmd_block, cmd_page, cmd_col, cmd_len, wr_data} = '0;
    cmd_op = NCI_OP_READ;
    rs = 32'hd2b1a43b;
    repeat (5) @(posedge ref_clk);
    chk(chip_sel_n === 1'b1 && write_protect_n === 1'b0 && io_oe === 1'b0, "reset pins");
    reset_n <= 1'b1;
    rs = lfsr(rs);
    r1 = rs[17:0];
    r2 = r1 ^ 18'h80;
    c0 = {1'b0, rs[28:18]};
    for (int s = 0; s < 2; s++) begin
      slow <= (s == 1);
      exp_rd(r1, 12'd2108, 4);
      req(NCI_OP_READ, r1, 12'd2108, 13'd8);
    end
    exp_rd(r1, 12'd100, 3);
    req(NCI_OP_RAND_OUT, r1, 12'd100, 13'd3);
    exp_rd(r1, 12'd103, 2);
    req(NCI_OP_READ_CONT, r1, 12'd0, 13'd2);
    fill(r2, c0, 5);
    req(NCI_OP_PROGRAM, r2, c0, 13'd5);
    refuse(NCI_OP_PROGRAM, c0, 13'd5);
    exp_rd(r2, c0, 6);
    req(NCI_OP_READ, r2, c0, 13'd6);
    fill(r1 ^ 18'h1, 12'd2107, 5);
    req(NCI_OP_PROGRAM, r1 ^ 18'h1, 12'd2107, 13'd5);
    exp_rd(r1 ^ 18'h1, 12'd2107, 5);
    req(NCI_OP_READ, r1 ^ 18'h1, 12'd2107, 13'd5);
    refuse(NCI_OP_PROGRAM, 12'd0, 13'd0);
    refuse(NCI_OP_PROGRAM, 12'd2110, 13'd3);
    refuse(NCI_OP_CACHE_EXIT, 12'd0, 13'd0);
    exp_rd(r2, 12'h000, 4);
    req(NCI_OP_CACHE, r2, 12'h7ff, 13'd4);
    chk(cache_on === 1'b1, "cache on");
    refuse(NCI_OP_RAND_OUT, 12'd0, 13'd1);
    refuse(NCI_OP_READ, 12'd0, 13'd1);
    exp_rd(r2, 12'd4, 2112);
    req(NCI_OP_STREAM, r2, 12'd0, 13'd2112);
    expq.push_back(10'h100);
    req(NCI_OP_CACHE_EXIT, r2, 12'd0, 13'd0);
    @(posedge ref_clk);
    chk(cache_on === 1'b0, "cache off");
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(chip_sel_n === 1'b1 && io_oe === 1'b0, "reset pins");
    reset_n <= 1'b1;
    exp_rd(r1, 12'd0, 2);
    req(NCI_OP_READ, r1, 12'd0, 13'd2);
    @(posedge ref_clk);
    chk(nci_flash_model_i.faults == 0, "flash protocol");
    chk(expq.size() == 0, "missing result");
    test_done();
  end
endmodule // nci_host_bench

// ### testbench/nci_host_props.sv
`timescale 1ns/1ns
module nci_host_props import nci_pkg::*; #(
  parameter int PAGE_BYTES = 2112
) (
  input wire logic        ref_clk,           // Clock
  input wire logic        reset_n,           // Reset, low active
  input wire logic        cmd_valid,         // Request
  input wire logic        cmd_ready,         // Idle
  input wire nci_op_e     cmd_op,            // Operation
  input wire logic [11:0] cmd_col,           // Column
  input wire logic [12:0] cmd_len,           // Byte count
  input wire logic        op_err,            // Refused
  input wire logic        cache_on,          // Cache read running
  input wire logic        chip_sel_n,        // Select
  input wire logic        cmd_latch_strobe,  // Command latch
  input wire logic        addr_latch_strobe, // Address latch
  input wire logic        write_strobe_n,    // Write strobe
  input wire logic        read_strobe_n,     // Read strobe
  input wire logic        write_protect_n,   // Write protect
  input wire logic [7:0]  io_out,            // Data out
  input wire logic        io_oe,             // Data drive enable
  input wire logic        busy_flag_n        // Ready/busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = cmd_valid && cmd_ready;

  a_standby_quiet: assert property (
    chip_sel_n |-> write_strobe_n && read_strobe_n) else $error("Strobe while deselected");
  a_latch_excl: assert property (
    cmd_latch_strobe |-> !addr_latch_strobe) else $error("Both latches high");
  a_write_cycle: assert property (
    !write_strobe_n |-> !chip_sel_n && read_strobe_n && io_oe) else $error("Bad write cycle");
  a_write_width: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n[*3] ##1 write_strobe_n)
    else $error("Write strobe width");
  a_latch_hold: assert property (
    !write_strobe_n |=> write_strobe_n || ($stable(io_out) && $stable(cmd_latch_strobe)
      && $stable(addr_latch_strobe))) else $error("Lines moved in write strobe");
  a_read_width: assert property (
    $fell(read_strobe_n) |-> !read_strobe_n[*6] ##1 read_strobe_n)
    else $error("Read strobe width");
  a_read_ready: assert property (
    $fell(read_strobe_n) |-> busy_flag_n && !io_oe && !cmd_latch_strobe && !addr_latch_strobe)
    else $error("Read strobe while busy or driving");
  a_prog_protect: assert property (
    !write_strobe_n && cmd_latch_strobe && (io_out == 8'h80 || io_out == 8'h10)
      |-> write_protect_n) else $error("Program code with protect low");
  a_exit_refused: assert property (
    take && cmd_op == NCI_OP_CACHE_EXIT && !cache_on |-> ##[1:2] op_err)
    else $error("Exit outside cache read taken");
  a_rand_refused: assert property (
    take && cmd_op == NCI_OP_RAND_OUT && cache_on |-> ##[1:2] op_err)
    else $error("Random output in cache read taken");
  a_len_refused: assert property (
    take && cmd_op == NCI_OP_PROGRAM && (cmd_len == 13'h0
      || 14'(cmd_col) + 14'(cmd_len) > 14'(PAGE_BYTES)) |-> ##[1:2] op_err)
    else $error("Bad program length taken");
endmodule // nci_host_props

bind nci_host nci_host_props #(.PAGE_BYTES(PAGE_BYTES)) nci_host_props_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_col(cmd_col), .cmd_len(cmd_len), .op_err(op_err),
  .cache_on(cache_on), .chip_sel_n(chip_sel_n), .cmd_latch_strobe(cmd_latch_strobe),
  .addr_latch_strobe(addr_latch_strobe), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n), .io_out(io_out),
  .io_oe(io_oe), .busy_flag_n(busy_flag_n));
